/* hdl/icd_pkg.sv */
/*
 Constants, opcode map and types for the initiator command decoder.
 Assumes one clock domain and a bus engine that performs the bus steps.
*/
// Operation
// R01 - Classify commands into four role groups; code drives only ICD_GRP_INIT and ICD_GRP_PROG
// R02 - Sequential opcode runs whole bus sequence
// R03 - Sequential commands only via command register
// R04 - Discrete commands via register or program
// R05 - Codes 08h-0Dh are elementary bus steps
// R06 - Special commands only from program memory
// R07 - Opcodes 00h-04h select plus message/command
// R08 - Opcodes 05h-07h run without selection
// R09 - 10h-17h data transfers, low bits select
// R10 - 18h-1Ch single message/command/status, operand
// R11 - Host loads target ID before selecting
// R12 - Message bytes precede command block
// R13 - Host loads message length first
// R14 - N-byte command uses host byte count
// R15 - Long message receive uses byte count
// R16 - Multi-message sends use N-byte forms
// R17 - Manual ack mode completes with ACK held
// R18 - Byte count must be 02h or more
// R19 - Outbound buffer locked; send from zero
// R20 - Inbound buffer must be drained first
// R21 - Program run locks memory and buffers
// R22 - Opcodes 0Eh, 0Fh start nothing
// R23 - Full 8-bit decode; idle write starts
package icd_pkg;
    localparam int ICD_OP_W = 8;
    localparam int ICD_CNT_W = 8;
    localparam int ICD_ID_W = 3;
    localparam int ICD_PTR_W = 5;
    localparam logic [7:0] ICD_SEQ_LAST = 8'h07;
    localparam logic [7:0] ICD_DISC_FIRST = 8'h08;
    localparam logic [7:0] ICD_ELEM_LAST = 8'h0d;
    localparam logic [7:0] ICD_DATA_FIRST = 8'h10;
    localparam logic [7:0] ICD_DATA_LAST = 8'h17;
    localparam logic [7:0] ICD_MCS_LAST = 8'h1c;
    localparam logic [7:0] ICD_SPECIAL_FIRST = 8'h1d;
    localparam logic [7:0] ICD_OP_SEL_CMD = 8'h00;
    localparam logic [7:0] ICD_OP_SEL_1MSG_CMD = 8'h01;
    localparam logic [7:0] ICD_OP_SEL_NMSG_CMD = 8'h02;
    localparam logic [7:0] ICD_OP_SEL_1MSG = 8'h03;
    localparam logic [7:0] ICD_OP_SEL_NMSG = 8'h04;
    localparam logic [7:0] ICD_OP_SEND_NMSG = 8'h05;
    localparam logic [7:0] ICD_OP_SEND_NCMD = 8'h06;
    localparam logic [7:0] ICD_OP_RECV_NMSG = 8'h07;
    localparam logic [7:0] ICD_OP_SEL = 8'h08;
    localparam logic [7:0] ICD_OP_SEL_ATN = 8'h09;
    localparam logic [7:0] ICD_OP_ATN_SET = 8'h0a;
    localparam logic [7:0] ICD_OP_ATN_CLR = 8'h0b;
    localparam logic [7:0] ICD_OP_ACK_SET = 8'h0c;
    localparam logic [7:0] ICD_OP_ACK_CLR = 8'h0d;
    localparam logic [7:0] ICD_OP_SEND_1MSG = 8'h18;
    localparam logic [7:0] ICD_OP_SEND_1MSG_ATN = 8'h19;
    localparam logic [7:0] ICD_OP_RECV_MSG = 8'h1a;
    localparam logic [7:0] ICD_OP_SEND_CMD = 8'h1b;
    localparam logic [7:0] ICD_OP_RECV_STAT = 8'h1c;
    localparam logic [7:0] ICD_MIN_COUNT = 8'h02;
    localparam logic [4:0] ICD_BUF_START = 5'h00;
    localparam int ICD_PADDING_BIT = 2;
    localparam int ICD_RECV_BIT = 1;
    localparam int ICD_DMA_BIT = 0;

    typedef enum logic [1:0] {
        ICD_GRP_INIT = 2'h0,
        ICD_GRP_TARGET = 2'h1,
        ICD_GRP_COMMON = 2'h2,
        ICD_GRP_PROG = 2'h3
    } icd_group_t;

    typedef enum logic [1:0] {
        ICD_ASG_SEQ = 2'h0,
        ICD_ASG_DISC = 2'h1,
        ICD_ASG_SPEC = 2'h2,
        ICD_ASG_NONE = 2'h3
    } icd_assign_t;

    // Bus steps handed to the bus engine
    typedef enum logic [3:0] {
        ICD_STEP_IDLE = 4'h0,
        ICD_STEP_SELECT = 4'h1,
        ICD_STEP_SELECT_ATN = 4'h2,
        ICD_STEP_MSG_OUT = 4'h3,
        ICD_STEP_CMD_OUT = 4'h4,
        ICD_STEP_MSG_IN = 4'h5,
        ICD_STEP_STAT_IN = 4'h6,
        ICD_STEP_DATA = 4'h7,
        ICD_STEP_ATN_SET = 4'h8,
        ICD_STEP_ATN_CLR = 4'h9,
        ICD_STEP_ACK_SET = 4'ha,
        ICD_STEP_ACK_CLR = 4'hb
    } icd_step_t;

    // Sequencer states Gray-coded in listed order, IDLE through DONE
    typedef enum logic [2:0] {
        ICD_ST_IDLE = 3'b000,
        ICD_ST_SELECT = 3'b001,
        ICD_ST_MSG = 3'b011,
        ICD_ST_CMD = 3'b010,
        ICD_ST_SINGLE = 3'b110,
        ICD_ST_DONE = 3'b111
    } icd_state_t;
endpackage

/* hdl/icd_classify.sv */
/*
 Opcode classifier: command type and assignment by opcode and source.
 Assumes a full 8-bit opcode; purely combinational.
*/
`timescale 1ns/10ps
module icd_classify import icd_pkg::*; (
    input wire logic [7:0] opcode,
    input wire logic from_program,
    output icd_assign_t assign_kind,
    output icd_group_t group,
    output logic legal
);
    always_comb begin
        group = ICD_GRP_INIT; // [R01]
        if (opcode <= ICD_SEQ_LAST) begin
            assign_kind = ICD_ASG_SEQ;
        end else if (opcode <= ICD_ELEM_LAST) begin
            assign_kind = ICD_ASG_DISC;
        end else if (opcode < ICD_DATA_FIRST) begin
            assign_kind = ICD_ASG_NONE; // [R22]
        end else if (opcode <= ICD_MCS_LAST) begin
            assign_kind = ICD_ASG_DISC;
        end else begin
            assign_kind = ICD_ASG_SPEC;
            group = ICD_GRP_PROG;
        end
        case (assign_kind)
            ICD_ASG_SEQ: legal = !from_program; // [R03]
            ICD_ASG_DISC: legal = 1'b1; // [R04]
            ICD_ASG_SPEC: legal = from_program; // [R06]
            default: legal = 1'b0;
        endcase
    end
endmodule

/* hdl/icd_decoder.sv */
/*
 Initiator command decoder and sequencer.
 Accepts opcodes from the command register or the program fetcher and hands
 bus steps to a bus engine, which answers with step_done. Assumes the engine
 reads the outbound buffer from step_addr and reports received lengths.
*/
`timescale 1ns/10ps
module icd_decoder import icd_pkg::*; #(
    parameter int CNT_W = ICD_CNT_W
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic cmd_wr,
    input wire logic [7:0] cmd_opcode,
    input wire logic prog_valid,
    input wire logic [7:0] prog_opcode,
    input wire logic [7:0] prog_operand,
    input wire logic prog_running,
    input wire logic manual_ack_mode,
    input wire logic [CNT_W-1:0] transfer_byte_count,
    input wire logic [2:0] selection_target_id,
    input wire logic step_done,
    input wire logic inbound_pending,
    output logic busy,
    output logic cmd_accept,
    output logic cmd_reject,
    output logic cmd_done,
    output icd_step_t step,
    output logic step_start,
    output logic [CNT_W-1:0] step_count,
    output logic [4:0] step_addr,
    output logic [2:0] step_target_id,
    output logic [2:0] data_mode,
    output logic ack_held,
    output logic atn_held,
    output logic host_outbound_lock,
    output logic host_inbound_lock,
    output logic host_progmem_lock
);
    ////////////////////////////////////////////////////////////////////////
    // Request selection and classification
    logic req;
    logic [7:0] req_op;
    logic req_prog;
    icd_assign_t req_kind;
    logic req_legal;
    logic needs_count;
    logic is_receive;
    icd_state_t state_r;
    logic [7:0] op_r;
    logic [7:0] operand_r;
    logic prog_r;

    function automatic logic op_uses_count(input logic [7:0] op);
        op_uses_count = (op == ICD_OP_SEL_NMSG_CMD) || (op == ICD_OP_SEL_NMSG)
            || (op == ICD_OP_SEND_NMSG) || (op == ICD_OP_SEND_NCMD)
            || (op == ICD_OP_RECV_NMSG);
    endfunction

    function automatic logic op_sends(input logic [7:0] op);
        op_sends = op <= ICD_OP_SEND_NCMD || op == ICD_OP_SEND_1MSG
            || op == ICD_OP_SEND_1MSG_ATN || op == ICD_OP_SEND_CMD;
    endfunction

    function automatic logic op_receives(input logic [7:0] op);
        op_receives = (op == ICD_OP_RECV_NMSG) || (op == ICD_OP_RECV_MSG)
            || (op == ICD_OP_RECV_STAT);
    endfunction

    assign req = cmd_wr || prog_valid;
    assign req_prog = !cmd_wr && prog_valid;
    assign req_op = cmd_wr ? cmd_opcode : prog_opcode;
    assign needs_count = op_uses_count(req_op);
    assign is_receive = op_receives(req_op);

    icd_classify u_classify (
        .opcode(req_op),
        .from_program(req_prog),
        .assign_kind(req_kind),
        .group(),
        .legal(req_legal)
    );

    logic go;
    logic bad;
    always_comb begin
        bad = !req_legal; // [R03] [R06] [R22]
        if (needs_count && transfer_byte_count < CNT_W'(ICD_MIN_COUNT)) begin
            bad = 1'b1; // [R18]
        end
        if (is_receive && inbound_pending) begin
            bad = 1'b1; // [R20]
        end
        if (ack_held && req_op != ICD_OP_ACK_CLR && req_op >= ICD_DATA_FIRST) begin
            bad = 1'b1; // [R17]
        end
        go = req && state_r == ICD_ST_IDLE && !bad; // [R23]
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    logic elem_op;
    assign elem_op = op_r >= ICD_DISC_FIRST && op_r <= ICD_ELEM_LAST;

    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= ICD_ST_IDLE;
            op_r <= 8'h00;
            operand_r <= 8'h00;
            prog_r <= 1'b0;
        end else begin
            case (state_r)
                ICD_ST_IDLE: begin
                    if (go) begin
                        op_r <= req_op;
                        operand_r <= prog_operand;
                        prog_r <= req_prog;
                        if (req_op <= ICD_OP_SEL_NMSG) begin
                            state_r <= ICD_ST_SELECT; // [R07] [R02]
                        end else if (req_op == ICD_OP_SEND_NMSG
                                || req_op == ICD_OP_RECV_NMSG) begin
                            state_r <= ICD_ST_MSG; // [R08]
                        end else if (req_op == ICD_OP_SEND_NCMD) begin
                            state_r <= ICD_ST_CMD; // [R08] [R14]
                        end else begin
                            state_r <= ICD_ST_SINGLE; // [R05] [R09] [R10]
                        end
                    end
                end
                ICD_ST_SELECT: begin
                    if (step_done) begin
                        state_r <= (op_r == ICD_OP_SEL_CMD) ? ICD_ST_CMD : ICD_ST_MSG;
                    end
                end
                ICD_ST_MSG: begin
                    if (step_done) begin
                        if (op_r == ICD_OP_SEL_1MSG_CMD || op_r == ICD_OP_SEL_NMSG_CMD) begin
                            state_r <= ICD_ST_CMD; // [R12]
                        end else begin
                            state_r <= ICD_ST_DONE;
                        end
                    end
                end
                ICD_ST_CMD, ICD_ST_SINGLE: begin
                    if (step_done) begin
                        state_r <= ICD_ST_DONE;
                    end
                end
                ICD_ST_DONE: state_r <= ICD_ST_IDLE;
                default: state_r <= ICD_ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Step issue
    logic entering;
    icd_step_t step_nxt;
    logic [CNT_W-1:0] count_nxt;
    logic [4:0] addr_nxt;
    logic [4:0] msg_len_r;

    always_comb begin
        step_nxt = ICD_STEP_IDLE;
        count_nxt = '0;
        addr_nxt = ICD_BUF_START; // [R19]
        case (state_r)
            ICD_ST_SELECT: step_nxt = ICD_STEP_SELECT;
            ICD_ST_MSG: begin
                step_nxt = (op_r == ICD_OP_RECV_NMSG) ? ICD_STEP_MSG_IN : ICD_STEP_MSG_OUT;
                count_nxt = op_uses_count(op_r) ? transfer_byte_count
                    : CNT_W'(1); // [R13] [R15] [R16]
            end
            ICD_ST_CMD: begin
                step_nxt = ICD_STEP_CMD_OUT;
                count_nxt = transfer_byte_count; // [R14]
                addr_nxt = msg_len_r; // [R12]
            end
            ICD_ST_SINGLE: begin
                if (op_r >= ICD_DATA_FIRST && op_r <= ICD_DATA_LAST) begin
                    step_nxt = ICD_STEP_DATA; // [R09]
                end else begin
                    case (op_r)
                        ICD_OP_SEL: step_nxt = ICD_STEP_SELECT;
                        ICD_OP_SEL_ATN: step_nxt = ICD_STEP_SELECT_ATN;
                        ICD_OP_ATN_SET: step_nxt = ICD_STEP_ATN_SET;
                        ICD_OP_ATN_CLR: step_nxt = ICD_STEP_ATN_CLR;
                        ICD_OP_ACK_SET: step_nxt = ICD_STEP_ACK_SET;
                        ICD_OP_ACK_CLR: step_nxt = ICD_STEP_ACK_CLR;
                        ICD_OP_SEND_1MSG, ICD_OP_SEND_1MSG_ATN: step_nxt = ICD_STEP_MSG_OUT;
                        ICD_OP_RECV_MSG: step_nxt = ICD_STEP_MSG_IN;
                        ICD_OP_SEND_CMD: step_nxt = ICD_STEP_CMD_OUT;
                        ICD_OP_RECV_STAT: step_nxt = ICD_STEP_STAT_IN;
                        default: step_nxt = ICD_STEP_IDLE;
                    endcase
                    if (op_r >= ICD_OP_SEND_1MSG) begin
                        count_nxt = CNT_W'(1);
                        if (prog_r) begin
                            addr_nxt = operand_r[4:0]; // [R10]
                        end
                    end
                end
            end
            default: step_nxt = ICD_STEP_IDLE;
        endcase
    end

    logic [2:0] state_prev_r;
    assign entering = state_r != icd_state_t'(state_prev_r) && state_r != ICD_ST_IDLE
        && state_r != ICD_ST_DONE;

    always_ff @(posedge clk) begin
        if (srst) begin
            state_prev_r <= ICD_ST_IDLE;
            step <= ICD_STEP_IDLE;
            step_start <= 1'b0;
            step_count <= '0;
            step_addr <= ICD_BUF_START;
            step_target_id <= 3'h0;
            data_mode <= 3'h0;
            msg_len_r <= ICD_BUF_START;
        end else begin
            state_prev_r <= state_r;
            step_start <= entering;
            if (entering) begin
                step <= step_nxt;
                step_count <= count_nxt;
                step_addr <= addr_nxt;
                step_target_id <= selection_target_id; // [R11]
                data_mode <= op_r[2:0]; // [R09]
                if (state_r == ICD_ST_MSG) begin
                    msg_len_r <= count_nxt[4:0]; // [R12]
                end
            end
            if (state_r == ICD_ST_IDLE) begin
                step <= ICD_STEP_IDLE;
                msg_len_r <= ICD_BUF_START;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Handshake, line holds and host locks
    always_ff @(posedge clk) begin
        if (srst) begin
            busy <= 1'b0;
            cmd_accept <= 1'b0;
            cmd_reject <= 1'b0;
            cmd_done <= 1'b0;
        end else begin
            cmd_accept <= go;
            cmd_reject <= req && !go;
            cmd_done <= state_r == ICD_ST_DONE;
            busy <= go || (state_r != ICD_ST_IDLE && state_r != ICD_ST_DONE);
        end
    end

    logic last_transfer;
    assign last_transfer = step_done && (state_r == ICD_ST_CMD || state_r == ICD_ST_MSG
        || (state_r == ICD_ST_SINGLE && !elem_op));

    always_ff @(posedge clk) begin
        if (srst) begin
            ack_held <= 1'b0;
            atn_held <= 1'b0;
        end else begin
            if (last_transfer && manual_ack_mode) begin
                ack_held <= 1'b1; // [R17]
            end else if (state_r == ICD_ST_SINGLE && step_done) begin
                if (op_r == ICD_OP_ACK_CLR) begin
                    ack_held <= 1'b0;
                end else if (op_r == ICD_OP_ACK_SET) begin
                    ack_held <= 1'b1;
                end
            end
            if (state_r == ICD_ST_SINGLE && step_done) begin
                if (op_r == ICD_OP_ATN_SET || op_r == ICD_OP_SEL_ATN
                        || op_r == ICD_OP_SEND_1MSG_ATN) begin
                    atn_held <= 1'b1;
                end else if (op_r == ICD_OP_ATN_CLR) begin
                    atn_held <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            host_outbound_lock <= 1'b0;
            host_inbound_lock <= 1'b0;
            host_progmem_lock <= 1'b0;
        end else begin
            host_outbound_lock <= prog_running || (op_sends(op_r)
                && state_r != ICD_ST_IDLE && state_r != ICD_ST_DONE); // [R19] [R21]
            host_inbound_lock <= prog_running || (op_receives(op_r)
                && state_r != ICD_ST_IDLE && state_r != ICD_ST_DONE); // [R20] [R21]
            host_progmem_lock <= prog_running; // [R21]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_cmd_sent;
        state_r == ICD_ST_CMD && step_start;
    endsequence

    chk_unassigned_idle: assert property (@(posedge clk) disable iff (srst) // [R22]
        (req && req_op > ICD_ELEM_LAST && req_op < ICD_DATA_FIRST) |=> !cmd_accept && cmd_reject)
        else $error("unassigned opcode accepted");
    chk_seq_not_prog: assert property (@(posedge clk) disable iff (srst) // [R03]
        (req_prog && req_op <= ICD_SEQ_LAST) |-> !go)
        else $error("sequential opcode taken from program");
    chk_special_reg: assert property (@(posedge clk) disable iff (srst) // [R06]
        (cmd_wr && cmd_opcode >= ICD_SPECIAL_FIRST) |-> !go)
        else $error("special opcode taken from register");
    chk_count_min: assert property (@(posedge clk) disable iff (srst) // [R18]
        (needs_count && transfer_byte_count < CNT_W'(ICD_MIN_COUNT)) |-> !go)
        else $error("short byte count accepted");
    chk_select_first: assert property (@(posedge clk) disable iff (srst) // [R07]
        (go && req_op <= ICD_OP_SEL_NMSG) |=> ##1 step_start && step == ICD_STEP_SELECT)
        else $error("selecting command skipped selection");
    chk_cmd_after_msg: assert property (@(posedge clk) disable iff (srst) // [R12]
        s_cmd_sent |-> $past(state_r, 2) != ICD_ST_IDLE || op_r == ICD_OP_SEND_NCMD
            || op_r == ICD_OP_SEL_CMD)
        else $error("command block before message");
    chk_ack_hold: assert property (@(posedge clk) disable iff (srst) // [R17]
        (last_transfer && manual_ack_mode) |=> ack_held)
        else $error("final ACK not held");
    chk_outbound_lock: assert property (@(posedge clk) disable iff (srst) // [R19]
        (state_r == ICD_ST_CMD) |=> host_outbound_lock)
        else $error("outbound buffer open during command");
    chk_prog_lock: assert property (@(posedge clk) disable iff (srst) // [R21]
        prog_running |=> host_progmem_lock && host_inbound_lock)
        else $error("program run left memory open");
    chk_recv_drain: assert property (@(posedge clk) disable iff (srst) // [R20]
        (is_receive && inbound_pending) |-> !go)
        else $error("receive with undrained inbound buffer");
endmodule

/* sim/icd_engine_model.sv */
/*
 Bus engine and target model: answers each step_start with one step_done.
 Assumes a single clock; the bench sets the answer delay in cycles.
*/
`timescale 1ns/10ps
module icd_engine_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic step_start,
    input wire logic [3:0] delay,
    output logic step_done
);
    initial step_done = 1'b0;
    // One answer per step, prompt or slow
    always begin
        @(negedge clk);
        step_done = 1'b0;
        if (step_start === 1'b1 && srst === 1'b0) begin
            repeat (delay) @(negedge clk);
            step_done = 1'b1;
        end
    end
endmodule

/* sim/icd_decoder_tb.sv */
/*
 Self-checking bench for the initiator command decoder.
 Assumes the engine model answers steps; all inputs change at falling edges.
*/
`timescale 1ns/10ps
module icd_decoder_tb import icd_pkg::*;;
    logic clk = 0, srst = 1, cmd_wr = 0, prog_valid = 0, prog_running = 0;
    logic manual_ack_mode = 0, inbound_pending = 0, ack_exp = 0;
    logic [7:0] cmd_opcode = 0, prog_opcode = 0, prog_operand = 0, cnt_r = 8'h02;
    logic [2:0] sel_id = 0;
    logic [3:0] eng_delay = 0;
    logic [31:0] seed = 32'h270bb2b9;
    logic step_done, busy, cmd_accept, cmd_reject, cmd_done, step_start;
    logic ack_held, atn_held, ob_lock, ib_lock, pm_lock;
    logic [7:0] step_count;
    logic [4:0] step_addr;
    logic [2:0] step_target_id, data_mode;
    icd_step_t step;
    icd_step_t st_q[$];
    logic [4:0] ad_q[$];
    logic [2:0] id_q[$], md_q[$];
    logic [1:0] lk_q[$];
    logic [7:0] cq[$];
    int err_count = 0, check_count = 0;

    always #4 clk = ~clk;

    icd_decoder dut (.clk(clk), .srst(srst), .cmd_wr(cmd_wr), .cmd_opcode(cmd_opcode),
        .prog_valid(prog_valid), .prog_opcode(prog_opcode), .prog_operand(prog_operand),
        .prog_running(prog_running), .manual_ack_mode(manual_ack_mode),
        .transfer_byte_count(cnt_r), .selection_target_id(sel_id), .step_done(step_done),
        .inbound_pending(inbound_pending), .busy(busy), .cmd_accept(cmd_accept),
        .cmd_reject(cmd_reject), .cmd_done(cmd_done), .step(step), .step_start(step_start),
        .step_count(step_count), .step_addr(step_addr), .step_target_id(step_target_id),
        .data_mode(data_mode), .ack_held(ack_held), .atn_held(atn_held),
        .host_outbound_lock(ob_lock), .host_inbound_lock(ib_lock),
        .host_progmem_lock(pm_lock));
    icd_engine_model eng (.clk(clk), .srst(srst), .step_start(step_start),
        .delay(eng_delay), .step_done(step_done));

    always @(negedge clk) begin
        if (step_start === 1'b1) begin
            st_q.push_back(step);
            ad_q.push_back(step_addr);
            id_q.push_back(step_target_id);
            md_q.push_back(data_mode);
            lk_q.push_back({ib_lock, ob_lock});
            cq.push_back(step_count);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic exp_ok(input logic [7:0] op, input logic pr, input logic inb);
        if (op == 8'h0e || op == 8'h0f || (!pr && op > ICD_MCS_LAST)) return 0;
        if (pr && op <= ICD_SEQ_LAST) return 0;
        if ((op == 2 || (op >= 4 && op <= 7)) && cnt_r < ICD_MIN_COUNT) return 0;
        if (inb && (op == 7 || op == 8'h1a || op == 8'h1c)) return 0;
        if (ack_exp && op >= 8'h10) return 0;
        return 1;
    endfunction

    function automatic icd_step_t exp_step(input logic [7:0] op, input int i);
        if (op <= 8'h04 && i == 0) return ICD_STEP_SELECT;
        if (op <= 8'h02 && i == (op == 0 ? 1 : 2)) return ICD_STEP_CMD_OUT;
        if (op >= 8'h01 && op <= 8'h04) return ICD_STEP_MSG_OUT;
        if (op > ICD_MCS_LAST) return ICD_STEP_IDLE;
        case (op)
            8'h05, 8'h18, 8'h19: return ICD_STEP_MSG_OUT;
            8'h06, 8'h1b: return ICD_STEP_CMD_OUT;
            8'h07, 8'h1a: return ICD_STEP_MSG_IN;
            8'h08: return ICD_STEP_SELECT;
            8'h09: return ICD_STEP_SELECT_ATN;
            8'h0a: return ICD_STEP_ATN_SET;
            8'h0b: return ICD_STEP_ATN_CLR;
            8'h0c: return ICD_STEP_ACK_SET;
            8'h0d: return ICD_STEP_ACK_CLR;
            8'h1c: return ICD_STEP_STAT_IN;
            default: return ICD_STEP_DATA;
        endcase
    endfunction

    function automatic logic [4:0] exp_addr(input logic [7:0] op, input logic pr,
            input logic [7:0] opd, input icd_step_t e);
        if (pr && op >= 8'h18) return opd[4:0];
        if (e != ICD_STEP_CMD_OUT || op > 8'h02) return ICD_BUF_START;
        return (op == 8'h01) ? 5'h01 : (op == 8'h02 ? cnt_r[4:0] : ICD_BUF_START);
    endfunction

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        while (cmd_done !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        if (cmd_done !== 1'b1) begin
            err_count++;
            report_and_stop();
        end
        @(negedge clk);
    endtask

    task automatic run(input logic [7:0] op, input logic pr, input logic [7:0] opd,
            input logic inb);
        logic ok;
        icd_step_t e;
        ok = exp_ok(op, pr, inb);
        st_q.delete();
        ad_q.delete();
        id_q.delete();
        md_q.delete();
        lk_q.delete();
        cq.delete();
        inbound_pending = inb;
        prog_running = pr;
        prog_opcode = op;
        prog_operand = opd;
        cmd_opcode = op;
        cmd_wr = !pr;
        prog_valid = pr;
        @(negedge clk);
        check("accept", cmd_accept, ok);
        check("reject", cmd_reject, !ok);
        check("pm_lock", pm_lock, pr);
        check("busy", busy, ok);
        cmd_wr = 0;
        prog_valid = 0;
        @(negedge clk);
        if (ok) begin
            wait_done();
            check("steps", 16'(st_q.size()), 16'(op <= 2 && op != 0 ? 3 : op <= 4 ? 2 : 1));
            foreach (st_q[i]) begin
                e = exp_step(op, i);
                check("step", st_q[i], e);
                check("addr", ad_q[i], exp_addr(op, pr, opd, e));
                if (e == ICD_STEP_SELECT) check("tid", id_q[i], sel_id);
                if (e == ICD_STEP_DATA) check("mode", md_q[i], op[2:0]);
                if (e == ICD_STEP_MSG_OUT || e == ICD_STEP_MSG_IN || op == 8'h06)
                    check("count", cq[i], (op inside {2, 4, 5, 6, 7}) ? cnt_r : 8'h01);
            end
            if (st_q.size() > 0) begin
                check("ob_lock", lk_q[0][0], pr || op <= 8'h06 || op == 8'h18 || op == 8'h19
                    || op == 8'h1b);
                check("ib_lock", lk_q[0][1], pr || op == 8'h07 || op == 8'h1a
                    || op == 8'h1c);
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] op;
        logic pr;
        repeat (20) @(negedge clk);
        srst = 0;
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 32; k++) begin
                sel_id = k[2:0];
                run(8'(k), p[0], 8'(k), 0);
                if (k == 8'h0c && p == 0) check("ack_set", ack_held, 1);
                if (k == 8'h0d) check("ack_clr", ack_held, 0);
                if (k == 8'h0a) check("atn_set", atn_held, 1);
                if (k == 8'h0b) check("atn_clr", atn_held, 0);
            end
        end
        eng_delay = 4'ha;
        cmd_opcode = ICD_OP_SEL;
        cmd_wr = 1;
        @(negedge clk);
        check("accept", cmd_accept, 1);
        cmd_opcode = ICD_OP_SEL_ATN;
        @(negedge clk);
        cmd_wr = 0;
        check("busy_rej", cmd_reject, 1);
        wait_done();
        manual_ack_mode = 1;
        run(ICD_OP_SEND_1MSG, 0, 0, 0);
        check("ack_held", ack_held, 1);
        ack_exp = 1;
        run(ICD_OP_SEND_CMD, 0, 0, 0);
        run(ICD_OP_ACK_CLR, 0, 0, 0);
        ack_exp = 0;
        check("ack_rel", ack_held, 0);
        manual_ack_mode = 0;
        repeat (80) begin
            op = 8'(xs() % 32);
            pr = xs() % 2;
            if (op == 8'h0c) op = 8'h0d;
            if (pr && op > ICD_MCS_LAST) op = 8'h18 + 8'(xs() % 5);
            cnt_r = 8'(xs() % 4);
            sel_id = 3'(xs());
            eng_delay = 4'(xs());
            run(op, pr, 8'(xs()), (op[7:3] != 5'h02) && xs() % 2);
        end
        report_and_stop();
    end
endmodule
